// ==== src/pcc_top.sv ====
// piezo channel control, protection and health reporting logic
//
// Behaviour
// - per-channel relay selects actuator or sensor
// - sensor mode routes piezo via gain amp
// - converter also samples each channel current
// - protection owns amplifier enable and relays
// - fault disables channel within tens of ms
// - bad cable interlock disables high voltage amplifier
// - active-low clear acts without serial clock
// - output starts only when enabled and protection permits; enable drop is ignored while a measured fault is pending
// - separate good status per channel
// - shared sample clock, four serial outputs
// - sample clock returned beside the data
// - eight-line diagnostic bus, outputs never enabled
// - twenty reserved lines stay inactive
// - health monitor flags out-of-range readings
// - protection state reported to management
// - management two-wire bus lines never driven
// - blue, green and red module indicators
`timescale 1ns/1ps
`default_nettype none
module pcc_top
   import pcc_pkg::*;
#(
   parameter int TRIP_CYC = PCC_TRIP_CYC,
   parameter int FRAME_BITS = PCC_FRAME_BITS
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic sense_clk,
   input wire pcc_pkg::pcc_conv_t drive1_conv,
   input wire pcc_pkg::pcc_conv_t drive2_conv,
   output pcc_pkg::pcc_conv_t drive1_dac,
   output pcc_pkg::pcc_conv_t drive2_dac,
   input wire logic drive1_power_en,
   input wire logic drive2_power_en,
   input wire logic [1:0] mode_sensor_req,
   output logic drive1_ok,
   output logic drive2_ok,
   output logic [1:0] relay_sensor,
   output logic [1:0] amp_enable,
   input wire logic [1:0] cable_interlock_sense,
   input wire logic [1:0] cable_id_short,
   input wire logic [1:0] cable_id_wrong,
   input wire logic [1:0] over_current,
   input wire logic [1:0] over_voltage,
   input wire logic [1:0] sense_sample,
   input wire logic [1:0] current_sample,
   output logic sense1_serial_out,
   output logic sense2_serial_out,
   output logic drive1_monitor_serial_out,
   output logic drive2_monitor_serial_out,
   output logic sense_return_clk,
   output logic sense_convert_n,
   input wire logic serial_diff_en,
   input wire logic double_rate_en,
   input wire logic sense1_gain_b0,
   input wire logic sense1_gain_b1,
   input wire logic sense2_gain_b0,
   input wire logic sense2_gain_b1,
   input wire logic sense1_gain_select,
   input wire logic sense2_gain_select,
   output logic [PCC_GAIN_W-1:0] sense1_gain,
   output logic [PCC_GAIN_W-1:0] sense2_gain,
   input wire logic [PCC_DIAG_W-1:0] diag_in,
   output logic [PCC_DIAG_W-1:0] diag_out,
   output logic [PCC_DIAG_W-1:0] diag_oe,
   input wire logic [PCC_EXT_W-1:0] ext_in,
   output logic [PCC_EXT_W-1:0] ext_out,
   output logic [PCC_EXT_W-1:0] ext_oe,
   input wire logic health_out_of_range,
   input wire logic health_critical,
   input wire logic hub_disable,
   input wire logic hot_plug_active,
   output logic health_event,
   output logic [1:0] protect_state,
   output logic mgmt_sda_in_unused,
   input wire logic mgmt_sda_in,
   input wire logic mgmt_scl_in,
   output logic mgmt_sda_oe,
   output logic mgmt_scl_oe,
   output pcc_pkg::pcc_leds_t module_leds
);
   import pcc_pkg::*;

   initial begin
      if (TRIP_CYC < 1 || TRIP_CYC >= (1 << PCC_CNT_W)) begin
         $error("TRIP_CYC out of range");
      end
      if (FRAME_BITS < 2 || FRAME_BITS > 64) begin
         $error("FRAME_BITS out of range");
      end
   end

   // ref_clk domain state
   typedef struct packed {
      logic [1:0][1:0] sync_a;
      logic [1:0][1:0] sync_b;
      logic [1:0][4:0] fsync_a;
      logic [1:0][4:0] fsync_b;
      logic [1:0] req_a;
      logic [1:0] req_b;
      logic [1:0] hsync_a;
      logic [1:0] hsync_b;
      logic [1:0][PCC_CNT_W-1:0] trip_cnt;
      pcc_state_t [1:0] st;
      logic [1:0] relay;
      logic [1:0] amp;
      logic [1:0] ok;
      logic event_q;
      logic [1:0] tog_a;
      logic [1:0] tog_b;
      logic [1:0] tog_c;
   } pcc_ref_t;

   pcc_ref_t r_q;
   pcc_ref_t r_d;

   logic [1:0] en_raw;
   logic [1:0][4:0] flt_raw;
   logic [1:0] gate_tog;
   assign en_raw = {drive2_power_en, drive1_power_en};

   genvar gi;
   generate
      for (gi = 0; gi < PCC_CHANNELS; gi++) begin : g_flt
         assign flt_raw[gi] = {~cable_interlock_sense[gi], cable_id_short[gi],
            cable_id_wrong[gi], over_current[gi], over_voltage[gi]};
      end
   endgenerate

   always_comb begin
      r_d = r_q;
      r_d.sync_a = {en_raw, mode_sensor_req};
      r_d.sync_b = r_q.sync_a;
      r_d.fsync_a = flt_raw;
      r_d.fsync_b = r_q.fsync_a;
      r_d.hsync_a = {health_critical, hub_disable};
      r_d.hsync_b = r_q.hsync_a;
      r_d.tog_b = r_q.tog_a;
      r_d.tog_c = r_q.tog_b;
      r_d.tog_a = gate_tog;
      // a critical level counts as an event as well as lighting red
      r_d.event_q = r_q.hsync_b[1];
      for (int c = 0; c < PCC_CHANNELS; c++) begin
         // interlock faults act at once; measured faults must persist
         if (r_q.fsync_b[c][4:2] != 3'h0 || r_q.hsync_b[0]) begin
            r_d.st[c] = PCC_TRIPPED;
            r_d.trip_cnt[c] = '0;
         end else if (r_q.fsync_b[c][1:0] != 2'h0) begin
            if (r_q.trip_cnt[c] >= PCC_CNT_W'(TRIP_CYC - 1)) begin
               r_d.st[c] = PCC_TRIPPED;
            end else begin
               r_d.trip_cnt[c] = r_q.trip_cnt[c] + PCC_CNT_W'(1);
            end
         end else begin
            r_d.trip_cnt[c] = '0;
            // re-arm needs enable dropped, so a trip is not silently cleared
            unique case (r_q.st[c])
               PCC_IDLE: if (r_q.sync_b[1][c]) r_d.st[c] = PCC_ARMED;
               PCC_ARMED: if (!r_q.sync_b[1][c]) r_d.st[c] = PCC_IDLE;
               PCC_TRIPPED: if (!r_q.sync_b[1][c]) r_d.st[c] = PCC_IDLE;
               default: r_d.st[c] = PCC_TRIPPED;
            endcase
         end
         r_d.relay[c] = (r_q.st[c] == PCC_TRIPPED) ? 1'b1 : r_q.sync_b[0][c];
         r_d.amp[c] = (r_d.st[c] == PCC_ARMED) && !r_d.relay[c];
         r_d.ok[c] = (r_d.st[c] != PCC_TRIPPED) && (r_q.fsync_b[c] == 5'h00);
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         r_q <= '0;
         r_q.relay <= 2'h3;
      end else begin
         r_q <= r_d;
      end
   end

   logic [1:0] hr_q;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         hr_q <= 2'h0;
      end else begin
         hr_q <= {hr_q[0], health_out_of_range};
      end
   end

   assign relay_sensor = r_q.relay;
   assign amp_enable = r_q.amp;
   assign drive1_ok = r_q.ok[0];
   assign drive2_ok = r_q.ok[1];
   assign health_event = hr_q[1] | r_q.event_q;
   assign protect_state = {r_q.st[1] == PCC_TRIPPED, r_q.st[0] == PCC_TRIPPED};
   assign module_leds.blue = hot_plug_active;
   assign module_leds.green = (r_q.st[0] != PCC_TRIPPED) && (r_q.st[1] != PCC_TRIPPED);
   assign module_leds.red = (protect_state != 2'h0) || r_q.hsync_b[1];

   // serial ports pass to the converters
   // clear passes straight, no clock needed
   assign drive1_dac = drive1_conv;
   assign drive2_dac = drive2_conv;

   logic [1:0][PCC_GAIN_W-1:0] gain_q;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         gain_q <= '0;
      end else begin
         if (sense1_gain_select) gain_q[0] <= {sense1_gain_b1, sense1_gain_b0};
         if (sense2_gain_select) gain_q[1] <= {sense2_gain_b1, sense2_gain_b0};
      end
   end
   assign sense1_gain = gain_q[0];
   assign sense2_gain = gain_q[1];

   assign diag_out = '0;
   assign diag_oe = '0;
   assign ext_out = '0;
   assign ext_oe = '0;
   assign mgmt_sda_oe = 1'b0;
   assign mgmt_scl_oe = 1'b0;
   assign mgmt_sda_in_unused = mgmt_sda_in & mgmt_scl_in & ^diag_in & ^ext_in;

   // sense_clk domain: serialiser for four sample streams
   typedef struct packed {
      logic [1:0] relay_a;
      logic [1:0] relay_b;
      logic [3:0][FRAME_BITS-1:0] shift;
      logic [7:0] bit_cnt;
      logic conv_n;
      logic [1:0] tog;
   } pcc_lnk_t;

   pcc_lnk_t l_q;
   pcc_lnk_t l_d;

   always_comb begin
      l_d = l_q;
      l_d.relay_a = r_q.relay;
      l_d.relay_b = l_q.relay_a;
      for (int k = 0; k < 4; k++) begin
         l_d.shift[k] = {l_q.shift[k][FRAME_BITS-2:0], 1'b0};
      end
      if (l_q.bit_cnt == 8'(FRAME_BITS - 1)) begin
         l_d.bit_cnt = '0;
         l_d.conv_n = 1'b0;
         for (int c = 0; c < 2; c++) begin
            // sensor stream only in sensor mode
            l_d.shift[c] = l_q.relay_b[c] ? {FRAME_BITS{sense_sample[c]}} : '0;
            l_d.shift[c+2] = {FRAME_BITS{current_sample[c]}};
            l_d.tog[c] = ~l_q.tog[c];
         end
      end else begin
         l_d.bit_cnt = l_q.bit_cnt + 8'h01;
         l_d.conv_n = 1'b1;
      end
   end

   always_ff @(posedge sense_clk or negedge reset_n) begin
      if (!reset_n) begin
         l_q <= '0;
         l_q.conv_n <= 1'b1;
      end else begin
         l_q <= l_d;
      end
   end

   assign gate_tog = l_q.tog;
   // four serial outputs on one clock
   assign sense1_serial_out = l_q.shift[0][FRAME_BITS-1];
   assign sense2_serial_out = l_q.shift[1][FRAME_BITS-1];
   assign drive1_monitor_serial_out = l_q.shift[2][FRAME_BITS-1];
   assign drive2_monitor_serial_out = l_q.shift[3][FRAME_BITS-1];
   // returned clock; config inputs accepted as-is
   assign sense_return_clk = sense_clk & (serial_diff_en | ~double_rate_en | 1'b1);
   assign sense_convert_n = l_q.conv_n;
endmodule
`default_nettype wire

// ==== src/pcc_pkg.sv ====
// shared types and constants for the piezo channel control and protection block
package pcc_pkg;
   localparam int PCC_CHANNELS = 2;
   localparam int PCC_GAIN_W = 2;
   localparam int PCC_DIAG_W = 8;
   localparam int PCC_EXT_W = 20;
   localparam int PCC_CLK_HZ = 40000000;
   // longest time from fault detection to disable, in microseconds
   localparam int PCC_TRIP_US = 20000;
   localparam int PCC_TRIP_CYC = PCC_TRIP_US * (PCC_CLK_HZ / 1000000);
   localparam int PCC_CNT_W = 24;
   // sampling word: serial bits per frame on the return link
   localparam int PCC_FRAME_BITS = 16;

   typedef enum logic [1:0] {
      PCC_IDLE = 2'b00,
      PCC_ARMED = 2'b01,
      PCC_TRIPPED = 2'b10
   } pcc_state_t;

   typedef struct packed {
      logic cable_open;
      logic cable_short;
      logic id_wrong;
      logic over_current;
      logic over_voltage;
   } pcc_fault_t;

   typedef struct packed {
      logic select_n;
      logic serial_clk;
      logic serial_in;
      logic clear_n;
   } pcc_conv_t;

   typedef struct packed {
      logic blue;
      logic green;
      logic red;
   } pcc_leds_t;

   typedef struct packed {
      logic sensor_mode;
      logic amp_en;
      logic ok;
   } pcc_chan_out_t;
endpackage

// ==== sim/pcc_top_asserts.sv ====
// port-level checks for the piezo channel control block
`timescale 1ns/1ps
`default_nettype none
module pcc_top_asserts
   import pcc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic sense_clk,
   input wire pcc_pkg::pcc_conv_t drive1_conv,
   input wire pcc_pkg::pcc_conv_t drive1_dac,
   input wire logic drive1_power_en,
   input wire logic [1:0] mode_sensor_req,
   input wire logic drive1_ok,
   input wire logic [1:0] relay_sensor,
   input wire logic [1:0] amp_enable,
   input wire logic [1:0] cable_interlock_sense,
   input wire logic [1:0] cable_id_short,
   input wire logic [1:0] cable_id_wrong,
   input wire logic hub_disable,
   input wire logic [1:0] protect_state,
   input wire logic sense_return_clk,
   input wire logic sense1_gain_b0,
   input wire logic sense1_gain_b1,
   input wire logic sense1_gain_select,
   input wire logic [PCC_GAIN_W-1:0] sense1_gain,
   input wire logic [PCC_DIAG_W-1:0] diag_oe,
   input wire logic [PCC_EXT_W-1:0] ext_oe
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // margin of six covers the two-stage sync plus state update
   sequence s_en_held;
      (drive1_power_en && cable_interlock_sense[0] && !mode_sensor_req[0] && !hub_disable
         && !cable_id_short[0] && !cable_id_wrong[0]) [*6];
   endsequence
   a_enable_arms: assert property (s_en_held ##0 !protect_state[0] |-> amp_enable[0])
      else $error("amplifier not armed");
   a_en_drop_off: assert property (!drive1_power_en [*6] |-> !amp_enable[0])
      else $error("amplifier on without enable");
   a_plug_trips: assert property (!cable_interlock_sense[0] [*6] |-> !amp_enable[0])
      else $error("amplifier on with bad plug");
   a_amp_actuator: assert property (amp_enable[0] |-> !relay_sensor[0])
      else $error("amplifier on in sensor position");
   a_ok_on_trip: assert property (protect_state[0] [*2] |-> !drive1_ok)
      else $error("good while tripped");
   a_conv_through: assert property (drive1_dac == drive1_conv)
      else $error("converter lines not passed");
   a_gain_latch: assert property (sense1_gain_select |=>
      sense1_gain == {$past(sense1_gain_b1), $past(sense1_gain_b0)})
      else $error("gain code not taken");
   a_gain_hold: assert property (!sense1_gain_select |=> $stable(sense1_gain))
      else $error("gain moved without select");
   a_spare_idle: assert property (diag_oe == '0 && ext_oe == '0)
      else $error("spare lines driven");
   a_clk_return: assert property (sense_return_clk == sense_clk)
      else $error("return clock differs");
endmodule
bind pcc_top pcc_top_asserts pcc_top_asserts_i (.ref_clk, .reset_n, .sense_clk,
   .drive1_conv, .drive1_dac, .drive1_power_en, .mode_sensor_req, .drive1_ok, .relay_sensor,
   .amp_enable, .cable_interlock_sense, .cable_id_short, .cable_id_wrong, .hub_disable,
   .protect_state, .sense_return_clk, .sense1_gain_b0, .sense1_gain_b1,
   .sense1_gain_select, .sense1_gain, .diag_oe, .ext_oe);
`default_nettype wire

// ==== sim/pcc_carrier_model.sv ====
// carrier-side model: sample clock in bursts, sample bits and link config
`timescale 1ns/1ps
`default_nettype none
module pcc_carrier_model (
   output logic sense_clk,
   output logic [1:0] sense_sample,
   output logic [1:0] current_sample,
   output logic serial_diff_en,
   output logic double_rate_en,
   input wire logic sense1_serial_out,
   input wire logic sense_return_clk,
   output logic [15:0] sense1_word
);
   logic [15:0] word_q;
   logic [3:0] smp_q = 4'h0;
   assign serial_diff_en = 1'h1;
   assign double_rate_en = 1'h0;
   assign {sense_sample, current_sample} = smp_q;
   assign sense1_word = word_q;
   // one shared clock, parked low between bursts of frames
   initial begin
      sense_clk = 1'h0;
      #3;
      forever begin
         repeat (64) #62.5 sense_clk = ~sense_clk;
         #250;
      end
   end
   // bits move every cycle so a stuck sampling path shows
   always @(negedge sense_clk) smp_q <= smp_q + 4'h5;
   always @(posedge sense_return_clk) word_q <= {word_q[14:0], sense1_serial_out};
endmodule
`default_nettype wire

// ==== sim/pcc_top_test.sv ====
// self-checking bench for the piezo channel control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin fails++; \
   $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module pcc_top_test;
   import pcc_pkg::*;
   localparam int TRIP = 16;
   // {mode, plug, short, wrong, en, amp, relay, ok, check relay, check ok}
   localparam logic [9:0] ROWS [6] = '{10'h137, 10'h32A, 10'h021, 10'h1A1, 10'h161, 10'h102};
   logic ref_clk = 1'h0;
   logic reset_n = 1'h0;
   logic [1:0] en = 2'h0, mode = 2'h0, plug = 2'h3, shrt = 2'h0, wrng = 2'h0;
   logic [1:0] oc = 2'h0, ov = 2'h0, gsel = 2'h0, amp, relay, pst, ss, cs, gain1, gain2;
   logic hor = 1'h0, hub = 1'h0, hot = 1'h0, ok1, ok2, hev, cnv, sclk, rclk, s1, lvds, ddr;
   logic crit = 1'h0;
   logic [15:0] word;
   logic [3:0] g = 4'h0;
   logic [9:0] r;
   pcc_conv_t conv1 = 4'h0, conv2 = 4'h0, dac1, dac2;
   pcc_leds_t leds;
   int comparisons = 0, fails = 0, k;
   always #12.5 ref_clk = ~ref_clk;
   pcc_carrier_model pcc_carrier_model_i (.sense_clk(sclk), .sense_sample(ss),
      .current_sample(cs), .serial_diff_en(lvds), .double_rate_en(ddr),
      .sense1_serial_out(s1), .sense_return_clk(rclk), .sense1_word(word));
   pcc_top #(.TRIP_CYC(TRIP), .FRAME_BITS(16)) pcc_top_i (.ref_clk, .reset_n, .sense_clk(sclk),
      .drive1_conv(conv1), .drive2_conv(conv2), .drive1_dac(dac1), .drive2_dac(dac2),
      .drive1_power_en(en[0]), .drive2_power_en(en[1]), .mode_sensor_req(mode),
      .drive1_ok(ok1), .drive2_ok(ok2), .relay_sensor(relay), .amp_enable(amp),
      .cable_interlock_sense(plug), .cable_id_short(shrt), .cable_id_wrong(wrng),
      .over_current(oc), .over_voltage(ov), .sense_sample(ss), .current_sample(cs),
      .sense1_serial_out(s1), .sense2_serial_out(), .drive1_monitor_serial_out(),
      .drive2_monitor_serial_out(), .sense_return_clk(rclk), .sense_convert_n(cnv),
      .serial_diff_en(lvds), .double_rate_en(ddr), .sense1_gain_b0(g[0]),
      .sense1_gain_b1(g[1]), .sense2_gain_b0(g[2]), .sense2_gain_b1(g[3]),
      .sense1_gain_select(gsel[0]), .sense2_gain_select(gsel[1]), .sense1_gain(gain1),
      .sense2_gain(gain2), .diag_in(8'h00), .diag_out(), .diag_oe(), .ext_in(20'h00000),
      .ext_out(), .ext_oe(), .health_out_of_range(hor), .health_critical(crit),
      .hub_disable(hub), .hot_plug_active(hot), .health_event(hev), .protect_state(pst),
      .mgmt_sda_in_unused(), .mgmt_sda_in(1'h1), .mgmt_scl_in(1'h1), .mgmt_sda_oe(),
      .mgmt_scl_oe(), .module_leds(leds));
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask
   // a trip only clears once enable has been low
   task automatic rearm();
      en = 2'h0;
      step(4);
      en = 2'h3;
      step(8);
   endtask
   task automatic print_verdict();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      step(3);
      `CHK("relay reset", 2'h3, relay)
      `CHK("ok reset", 2'h0, {ok2, ok1})
      step(3);
      reset_n = 1'h1;
      foreach (ROWS[i]) begin
         en = 2'h0;
         step(4);
         r = ROWS[i];
         mode = {2{r[9]}};
         plug = {2{r[8]}};
         shrt = {2{r[7]}};
         wrng = {2{r[6]}};
         step(1);
         en = {2{r[5]}};
         step(8);
         `CHK("amp", {2{r[4]}}, amp)
         if (r[1]) `CHK("relay", {2{r[3]}}, relay)
         if (r[0]) `CHK("ok", {2{r[2]}}, {ok2, ok1})
      end
      mode = 2'h0;
      plug = 2'h3;
      shrt = 2'h0;
      wrng = 2'h0;
      rearm();
      oc = 2'h1;
      step(TRIP - 6);
      oc = 2'h0;
      step(2);
      `CHK("brief overcurrent", 2'h3, amp)
      oc = 2'h1;
      step(TRIP + 6);
      `CHK("overcurrent trip", 2'h2, amp)
      `CHK("trip state", 2'h1, pst)
      `CHK("trip relay", 2'h1, relay)
      `CHK("green off", 1'h0, leds.green)
      oc = 2'h0;
      step(4);
      `CHK("trip latched", 2'h2, amp)
      rearm();
      `CHK("rearmed", 2'h3, amp)
      ov = 2'h2;
      step(TRIP + 6);
      `CHK("overvoltage trip", 2'h1, amp)
      ov = 2'h0;
      hub = 1'h1;
      step(6);
      `CHK("hub disable", 2'h0, amp)
      hub = 1'h0;
      rearm();
      for (int c = 0; c < 4; c++) begin
         g = {~c[1:0], c[1:0]};
         gsel = 2'h3;
         step(1);
         gsel = 2'h0;
         g = 4'h0;
         step(1);
         `CHK("gain1", c[1:0], gain1)
         `CHK("gain2", ~c[1:0], gain2)
      end
      conv1 = 4'h2;
      conv2 = 4'hD;
      #1;
      `CHK("clear pass", conv1, dac1)
      `CHK("serial pass", conv2, dac2)
      `CHK("health quiet", 1'h0, hev)
      `CHK("green", 1'h1, leds.green)
      `CHK("red quiet", 1'h0, leds.red)
      crit = 1'h1;
      step(6);
      `CHK("critical event", 1'h1, hev)
      `CHK("red", 1'h1, leds.red)
      crit = 1'h0;
      hor = 1'h1;
      hot = 1'h1;
      step(6);
      `CHK("health event", 1'h1, hev)
      `CHK("blue", 1'h1, leds.blue)
      // actuator mode on both channels: the sense stream must carry only zeros
      step(300);
      `CHK("sense stream idle", 16'h0000, word)
      k = 0;
      while (cnv !== 1'h0 && k < 400) begin
         step(1);
         k++;
      end
      `CHK("convert", 1'h0, cnv)
      reset_n = 1'h0;
      #3;
      `CHK("reset amp", 2'h0, amp)
      `CHK("reset relay", 2'h3, relay)
      step(6);
      reset_n = 1'h1;
      step(8);
      `CHK("amp after reset", 2'h3, amp)
      `CHK("relay after reset", 2'h0, relay)
      print_verdict();
   end
   initial begin
      #200000;
      fails++;
      print_verdict();
   end
endmodule
`default_nettype wire
